// >>> bench/msbl_boot_loader_chk.sv
// Checker on the boot loader top ports.
// Assumes en stays high while a boot runs.
`timescale 1ns/1ns
`default_nettype none
module msbl_chk
  import msbl_pkg::*;
(
  // Clock, reset
  input wire logic                   ref_clk,
  input wire logic                   rst_n,
  // Watched outputs
  input wire msbl_pkg::msbl_spi_out_t mst_out,
  input wire msbl_pkg::msbl_mst_en_t  mst_oe_n,
  input wire msbl_pkg::msbl_slv_en_t  slv_ie_n,
  input wire logic [1:0]             lnk_tx_w,
  input wire logic                   lnk_pd_en,
  input wire logic                   boot_done,
  input wire msbl_pkg::msbl_src_t     boot_src
);
  // Everything sampled on ref_clk, the link_clk outputs included; one reset for all
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  chk_clk_idle: assert property (mst_out.cs_n |-> !mst_out.sclk)
    else $error("clock high when idle");
  chk_clk_half: assert property ($rose(mst_out.sclk) |-> ##80 $fell(mst_out.sclk))
    else $error("bad half period");
  chk_mosi_hold: assert property (mst_out.sclk |-> $stable(mst_out.mosi))
    else $error("data moved in high phase");
  chk_pins_on: assert property (!mst_out.cs_n |-> mst_oe_n == 4'h0)
    else $error("select before pins");
  chk_one_path: assert property (mst_oe_n != 4'hF |-> boot_src == SRC_SPI_MST)
    else $error("master pins on other path");
  chk_slv_only: assert property (slv_ie_n != 3'h7 |-> mst_oe_n == 4'hF)
    else $error("slave path with master pins");
  chk_link_low: assert property (lnk_pd_en |-> lnk_tx_w == 2'h0)
    else $error("wires driven while disabled");
  chk_done_hold: assert property (boot_done |=> boot_done)
    else $error("done dropped");
  cover property ($rose(boot_done));
  cover property ($rose(mst_out.sclk));
  cover property (slv_ie_n == 3'h0);
endmodule
bind msbl_boot_loader msbl_chk i_msbl_chk (.*);
`default_nettype wire

// >>> bench/msbl_flash_mdl.sv
// Flash model for the boot read: mode 0, image is the bench byte pattern.
// Assumes one select frame per boot.
`timescale 1ns/1ns
`default_nettype none
module msbl_flash_mdl (
  // Pins from the loader
  input  wire logic   sclk,
  input  wire logic   cs_n,
  input  wire logic   mosi,
  // Data back, command seen
  output logic        miso,
  output logic [31:0] cmd
);
  int n = 0;
  initial miso = 1'b0;
  // Bit count restarts with each select
  always @(negedge cs_n) n = 0;
  // Command comes in MSB first on the rising clock
  always @(posedge sclk) begin
    if (!cs_n && n < 32) cmd = {cmd[30:0], mosi};
    n = n + 32'(!cs_n);
  end
  // Image bits change on the falling clock; an unused line toggles, not held
  always @(negedge sclk or posedge cs_n) begin
    miso = (!cs_n && n >= 32) ? 1'(8'(8'hC3 + 37 * ((n - 32) / 8)) >> (n - 32) % 8) : ~miso;
  end
endmodule
`default_nettype wire

// >>> bench/test_multi_source_boot_loader.sv
// Bench: one boot per reset, through each source in turn.
// Assumes the flash model on the master pins; OTP is answered here.
`timescale 1ns/1ns
`default_nettype none
module test_multi_source_boot_loader;
  import msbl_pkg::*;
  logic ref_clk = 0, link_clk = 0, rst_n = 0, img_ready = 0, mst_miso;
  logic slv_cs_n = 1, slv_sclk = 0, slv_mosi = 0, otp_rd, img_valid, boot_done;
  logic lnk_tx_oe_n, lnk_pd_en, chan0_alloc;
  logic [1:0] boot_sel = 0, lnk_rx_w = 0, lnk_tx_w;
  logic [15:0] img_len = 0;
  logic [10:0] otp_addr, a;
  logic [7:0] img_data;
  logic [31:0] otp_rdata = 0, cmd;
  msbl_spi_out_t mst_out;
  msbl_slv_en_t slv_ie_n;
  msbl_src_t boot_src;
  int error_cnt = 0, cmp_count = 0, cyc = 0;
  always #25 ref_clk = ~ref_clk;
  initial #7 forever #15 link_clk = ~link_clk;
  msbl_boot_loader i_msbl_boot_loader (.*, .en(1'b1), .mst_oe_n(), .boot_busy());
  msbl_flash_mdl i_msbl_flash_mdl (.sclk(mst_out.sclk), .cs_n(mst_out.cs_n),
    .mosi(mst_out.mosi), .miso(mst_miso), .cmd);
  function automatic logic [7:0] pat(input int i);
    return 8'(8'hC3 + 37 * i);
  endfunction
  // OTP word one cycle after the strobe, else not held; hang guard
  always @(posedge ref_clk) begin
    for (int n = 0; n < 4; n++)
      otp_rdata[8*n+:8] <= otp_rd ? pat(4 * otp_addr + n) : ~otp_rdata[8*n+:8];
    if (++cyc == 30000) begin
      error_cnt++;
      wrap_up();
    end
  end
  task automatic chk(input logic [31:0] g, e);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Strap is set before release, as the loader samples it then
  task automatic boot(input logic [1:0] s, input logic [15:0] l);
    rst_n <= 1'b0;
    boot_sel <= s;
    img_len <= l;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
  endtask
  task automatic take(input int i);
    int k = 0;
    @(negedge ref_clk);
    while (img_valid !== 1'b1 && k++ < 9000) @(negedge ref_clk);
    chk(img_data, pat(i));
    @(posedge ref_clk);
  endtask
  task automatic fin;
    int k = 0;
    while (boot_done !== 1'b1 && k++ < 500) @(negedge ref_clk);
    chk(boot_done, 1);
  endtask
  task automatic t_master;
    img_ready <= 1'b1;
    boot(2'h0, 16'h0002);
    take(0);
    take(1);
    chk(cmd, 32'h0300_0000);
    chk(boot_src, SRC_SPI_MST);
    fin();
  endtask
  // Host sends two bytes; idle clock level p picks mode 0/0 or 1/1
  task automatic t_slave(input logic p);
    img_ready <= 1'b0;
    slv_sclk <= p;
    boot(2'h1, 16'h0000);
    repeat (8) @(posedge ref_clk);
    chk(slv_ie_n, 3'h0);
    slv_cs_n <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      repeat (4) @(posedge ref_clk);
      slv_sclk <= 1'b0;
      slv_mosi <= 1'(pat(i / 8) >> i % 8);
      repeat (4) @(posedge ref_clk);
      slv_sclk <= 1'b1;
    end
    repeat (4) @(posedge ref_clk);
    slv_sclk <= p;
    slv_cs_n <= 1'b1;
    slv_mosi <= ~slv_mosi;
    img_ready <= 1'b1;
    take(0);
    take(1);
    fin();
  endtask
  // Consumer stalls until the FIFO stops the reads, then drains
  task automatic t_otp;
    img_ready <= 1'b0;
    boot(2'h3, 16'h0006);
    repeat (80) @(posedge ref_clk);
    a = otp_addr;
    repeat (20) @(posedge ref_clk);
    chk(otp_addr, a);
    chk(boot_done, 0);
    img_ready <= 1'b1;
    for (int i = 0; i < 6; i++) take(i);
    fin();
  endtask
  // One token: nine wire transitions, data LSB first, control flag last
  task automatic send_tok(input logic c, input logic [7:0] v);
    logic [8:0] t;
    t = {c, v};
    for (int i = 0; i < 9; i++) begin
      repeat (4) @(posedge ref_clk);
      lnk_rx_w[t[i]] <= ~lnk_rx_w[t[i]];
    end
  endtask
  task automatic t_link;
    int k = 0;
    img_ready <= 1'b0;
    boot(2'h2, 16'h0000);
    while (chan0_alloc !== 1'b1 && k++ < 99) @(posedge ref_clk);
    chk(k > 38 && k < 50, 1);
    repeat (9) @(posedge ref_clk);
    chk({lnk_tx_w, lnk_tx_oe_n, lnk_pd_en, chan0_alloc}, 5'h01);
    for (int i = 3; i >= 0; i--) send_tok(1'b0, NULL_DEST[8*i+:8]);
    send_tok(1'b0, pat(0));
    send_tok(1'b1, END_TOK);
    img_ready <= 1'b1;
    take(0);
    fin();
    chk(chan0_alloc, 0);
    chk(lnk_tx_w, 2'h0);
  endtask
  task automatic wrap_up;
    $display("compares %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    t_master();
    t_slave(1'b0);
    t_slave(1'b1);
    t_otp();
    t_link();
    wrap_up();
  end
endmodule
`default_nettype wire

// >>> pkg/msbl_pkg.sv
// Shared constants and carrier types of the multi-source boot loader.
// Assumes one loader per tile; the tile core clock is ref_clk at 20 MHz.
package msbl_pkg;

  // Timing
  localparam int unsigned CLK_NS       = 50;
  localparam int unsigned CORE_NOM_MHZ = 400;
  localparam int unsigned SPI_NOM_KHZ  = 2500;
  localparam int unsigned SPI_DIV      = CORE_NOM_MHZ * 1000 / SPI_NOM_KHZ;
  localparam logic [7:0]  SPI_HALF     = 8'(SPI_DIV / 2 - 1);
  localparam int unsigned LINK_EN_NS   = 2000;
  localparam logic [11:0] LINK_EN_CYC  = 12'((LINK_EN_NS + CLK_NS - 1) / CLK_NS);
  localparam int unsigned INIT_MAX_US  = 150;
  localparam logic [11:0] INIT_MAX_CYC = 12'(INIT_MAX_US * 1000 / CLK_NS);
  localparam logic [11:0] STRAP_WAIT   = 12'h004;

  // Flash command
  localparam logic [7:0]  FLASH_READ   = 8'h03;
  localparam logic [23:0] FLASH_ADDR   = 24'h00_0000;
  localparam logic [4:0]  CMD_LAST     = 5'h1F;

  // Link protocol
  localparam logic [31:0] NULL_DEST    = 32'h0000_FF02;
  localparam logic [7:0]  END_TOK      = 8'h01;
  localparam logic [3:0]  TOK_LAST     = 4'h8;
  localparam logic [1:0]  DEST_LAST    = 2'h3;

  // OTP
  localparam logic [15:0] OTP_BYTES    = 16'h2000;
  localparam logic [15:0] OTP_START    = 16'h0000;
  localparam int unsigned OTP_AW       = 11;

  // Image FIFO
  localparam int unsigned FIFO_W       = 8;
  localparam int unsigned FIFO_D       = 4;

  // Boot source strap coding
  typedef enum logic [1:0] {
    SRC_SPI_MST,
    SRC_SPI_SLV,
    SRC_LINK,
    SRC_OTP
  } msbl_src_t;

  // One link token: control flag over eight data bits
  typedef struct packed {
    logic       ctrl;
    logic [7:0] data;
  } msbl_tok_t;

  // SPI master output pins
  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic mosi;
  } msbl_spi_out_t;

  // SPI master pin enables, low while enabled
  typedef struct packed {
    logic miso;
    logic cs;
    logic sclk;
    logic mosi;
  } msbl_mst_en_t;

  // SPI slave pin enables, low while enabled
  typedef struct packed {
    logic cs;
    logic sclk;
    logic mosi;
  } msbl_slv_en_t;

endpackage

// >>> rtl/msbl_boot_loader.sv
// Boot-time image loader of one tile: SPI master, SPI slave, link or OTP source.
// Assumes straps and SPI pins come from outside and are synchronised here;
// the image consumer drains bytes from the FIFO on ref_clk.
`timescale 1ns/1ns
`default_nettype none
module msbl_boot_loader
  import msbl_pkg::*;
(
  // Core clock, reset, clock enable
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  input  wire logic                  en,
  // Boot source strap and image length
  input  wire logic [1:0]            boot_sel,
  input  wire logic [15:0]           img_len,
  // SPI master pins, fixed assignment
  input  wire logic                  mst_miso,
  output msbl_pkg::msbl_spi_out_t    mst_out,
  output msbl_pkg::msbl_mst_en_t     mst_oe_n,
  // SPI slave pins, fixed assignment
  input  wire logic                  slv_cs_n,
  input  wire logic                  slv_sclk,
  input  wire logic                  slv_mosi,
  output msbl_pkg::msbl_slv_en_t     slv_ie_n,
  // OTP memory port, one cycle read latency
  output logic                       otp_rd,
  output logic [OTP_AW-1:0]          otp_addr,
  input  wire logic [31:0]           otp_rdata,
  // Link
  input  wire logic                  link_clk,
  input  wire logic [1:0]            lnk_rx_w,
  output logic [1:0]                 lnk_tx_w,
  output logic                       lnk_tx_oe_n,
  output logic                       lnk_pd_en,
  // Image stream
  output logic                       img_valid,
  input  wire logic                  img_ready,
  output logic [7:0]                 img_data,
  // Status
  output logic                       chan0_alloc,
  output logic                       boot_busy,
  output logic                       boot_done,
  output msbl_pkg::msbl_src_t        boot_src
);
  typedef enum logic [3:0] {
    ST_WAIT,
    ST_SEL,
    ST_MST_EN,
    ST_MST_XFER,
    ST_SLV,
    ST_LNK_WAIT,
    ST_LNK_DEST,
    ST_LNK_IMG,
    ST_LNK_ACK,
    ST_OTP,
    ST_DRAIN,
    ST_DONE
  } msbl_state_t;

  typedef struct packed {
    msbl_state_t   st;
    msbl_src_t     src;
    logic [11:0]   wcnt;
    logic [15:0]   len;
    logic [15:0]   bcnt;
    logic [1:0]    sel_s1, sel_s2;
    logic          mi_s1, mi_s2;
    logic          cs_s1, cs_s2, cs_p;
    logic          ck_s1, ck_s2, ck_p;
    logic          mo_s1, mo_s2;
    logic [7:0]    div;
    logic [4:0]    bitc;
    logic          cmd;
    logic [31:0]   shift;
    logic [2:0]    b3;
    logic [7:0]    sh8;
    msbl_spi_out_t mo;
    msbl_mst_en_t  moe;
    msbl_slv_en_t  sie;
    logic          fv;
    logic [7:0]    fd;
    logic          ord;
    logic [OTP_AW-1:0] oaddr;
    logic          opend;
    logic          lnk_en;
    logic          rq_s1, rq_s2, rack;
    logic          treq, ta_s1, ta_s2;
    msbl_tok_t     ttok;
    logic [31:0]   dest;
    logic [1:0]    tokc;
    logic          chan0;
    logic          done;
  } msbl_st_t;

  msbl_st_t  q, d;
  msbl_tok_t rx_tok;
  logic      rx_req;
  logic      tx_ack;
  logic      fifo_ready;

  // Picks byte lane n of an OTP word, lane 0 lowest
  function automatic logic [7:0] otp_lane(input logic [31:0] w, input logic [1:0] n);
    otp_lane = w[8*n +: 8];
  endfunction

  assign mst_out     = q.mo;
  assign mst_oe_n    = q.moe;
  assign slv_ie_n    = q.sie;
  assign otp_rd      = q.ord;
  assign otp_addr    = q.oaddr;
  assign chan0_alloc = q.chan0;
  assign boot_done   = q.done;
  assign boot_busy   = (q.st != ST_WAIT) && (q.st != ST_DONE);
  assign boot_src    = q.src;

  // Next state of the loader
  always_comb begin
    logic tok_new;
    logic tok_take;
    logic sclk_rise;
    logic adv;
    tok_new   = (q.rq_s2 != q.rack);
    tok_take  = 1'b0;
    sclk_rise = q.ck_s2 && !q.ck_p;
    adv       = 1'b0;
    d = q;
    // Pin synchronisers; first stages feed only their second stages
    d.sel_s1 = boot_sel;
    d.sel_s2 = q.sel_s1;
    d.mi_s1  = mst_miso;
    d.mi_s2  = q.mi_s1;
    d.cs_s1  = slv_cs_n;
    d.cs_s2  = q.cs_s1;
    d.cs_p   = q.cs_s2;
    d.ck_s1  = slv_sclk;
    d.ck_s2  = q.ck_s1;
    d.ck_p   = q.ck_s2;
    d.mo_s1  = slv_mosi;
    d.mo_s2  = q.mo_s1;
    d.rq_s1  = rx_req;
    d.rq_s2  = q.rq_s1;
    d.ta_s1  = tx_ack;
    d.ta_s2  = q.ta_s1;
    d.ord    = 1'b0;
    // Pending byte leaves as soon as the FIFO takes it
    if (q.fv && fifo_ready) begin
      d.fv = 1'b0;
    end
    unique case (q.st)
      // Let the strap synchronisers settle, well inside the start limit
      ST_WAIT: begin
        d.wcnt = q.wcnt + 12'h001;
        if (q.wcnt == STRAP_WAIT - 12'h001) begin
          d.st = ST_SEL;
        end
      end
      // Strap is caught once; the path chosen stays until loaded
      ST_SEL: begin
        d.src  = msbl_src_t'(q.sel_s2);
        d.len  = q.len;
        d.wcnt = '0;
        d.bcnt = '0;
        d.len  = img_len;
        unique case (msbl_src_t'(q.sel_s2))
          SRC_SPI_MST: begin
            d.moe = '0;
            d.mo  = '{sclk: 1'b0, cs_n: 1'b1, mosi: 1'b0};
            d.div = SPI_HALF;
            d.st  = ST_MST_EN;
          end
          SRC_SPI_SLV: begin
            d.sie = '0;
            d.st  = ST_SLV;
          end
          SRC_LINK: begin
            d.st = ST_LNK_WAIT;
          end
          SRC_OTP: begin
            // The OTP holds only 8 KB; longer requests are clipped
            if (img_len > OTP_BYTES) begin
              d.len = OTP_BYTES;
            end
            d.bcnt = OTP_START;
            d.st   = ST_OTP;
          end
        endcase
      end
      // Pins stay enabled one half period before select drops
      ST_MST_EN: begin
        d.div = q.div - 8'h01;
        if (q.div == '0) begin
          d.div     = SPI_HALF;
          d.shift   = {FLASH_READ, FLASH_ADDR} << 1;
          d.mo.mosi = FLASH_READ[7];
          d.mo.cs_n = 1'b0;
          d.cmd     = 1'b1;
          d.bitc    = CMD_LAST;
          d.b3      = '0;
          d.st      = ST_MST_XFER;
        end
      end
      // Mode 0: data changes on the falling edge, sampled on the rising
      ST_MST_XFER: begin
        // A full pending byte holds the clock low so nothing is lost
        adv = (q.div == '0) && !(q.fv && !q.mo.sclk && !q.cmd);
        if (q.div != '0) begin
          d.div = q.div - 8'h01;
        end
        if (adv) begin
          d.div     = SPI_HALF;
          d.mo.sclk = ~q.mo.sclk;
          if (!q.mo.sclk) begin
            if (!q.cmd) begin
              d.sh8 = {q.mi_s2, q.sh8[7:1]};
              d.b3  = q.b3 + 3'h1;
              if (q.b3 == 3'h7) begin
                d.fv   = 1'b1;
                d.fd   = {q.mi_s2, q.sh8[7:1]};
                d.bcnt = q.bcnt + 16'h0001;
              end
            end
          end else if (q.cmd) begin
            if (q.bitc == '0) begin
              d.cmd = 1'b0;
            end else begin
              d.mo.mosi = q.shift[31];
              d.shift   = q.shift << 1;
              d.bitc    = q.bitc - 5'h01;
            end
          end
          // Stop on a falling edge once the image is in
          if (q.mo.sclk && q.bcnt == q.len && (!q.cmd || q.bitc == '0)) begin
            d.mo  = '{sclk: 1'b0, cs_n: 1'b1, mosi: 1'b0};
            d.moe = '1;
            d.st  = ST_DRAIN;
          end
        end
      end
      // Rising edge samples in both modes 0/0 and 1/1
      ST_SLV: begin
        if (!q.cs_s2 && sclk_rise) begin
          d.sh8 = {q.mo_s2, q.sh8[7:1]};
          d.b3  = q.b3 + 3'h1;
          if (q.b3 == 3'h7) begin
            // The host cannot be stalled; a byte still pending at a full FIFO is overwritten by the next
            d.fv   = 1'b1;
            d.fd   = {q.mo_s2, q.sh8[7:1]};
            d.bcnt = q.bcnt + 16'h0001;
          end
        end
        if (q.cs_s2 && !q.cs_p) begin
          d.b3 = '0;
          if (q.bcnt != '0) begin
            d.sie = '1;
            d.st  = ST_DRAIN;
          end
        end
      end
      ST_LNK_WAIT: begin
        d.wcnt = q.wcnt + 12'h001;
        if (q.wcnt == LINK_EN_CYC - 12'h001) begin
          d.lnk_en = 1'b1;
          d.chan0  = 1'b1;
          d.tokc   = '0;
          d.st     = ST_LNK_DEST;
        end
      end
      // First four data tokens form the acknowledge word, high byte first
      ST_LNK_DEST: begin
        if (tok_new) begin
          tok_take = 1'b1;
          if (!rx_tok.ctrl) begin
            d.dest = {q.dest[23:0], rx_tok.data};
            d.tokc = q.tokc + 2'h1;
            if (q.tokc == DEST_LAST) begin
              d.st = ST_LNK_IMG;
            end
          end
        end
      end
      // Image bytes, CRC included, until an END token
      ST_LNK_IMG: begin
        if (tok_new) begin
          if (rx_tok.ctrl) begin
            tok_take = 1'b1;
            if (rx_tok.data == END_TOK) begin
              d.tokc = '0;
              d.st   = ST_LNK_ACK;
            end
          end else if (!q.fv) begin
            tok_take = 1'b1;
            d.fv     = 1'b1;
            d.fd     = rx_tok.data;
            d.bcnt   = q.bcnt + 16'h0001;
          end
        end
      end
      // Route header from the top three bytes of the stored word, then END, unless null
      ST_LNK_ACK: begin
        if (q.treq == q.ta_s2) begin
          if (q.dest == NULL_DEST || q.tokc == 2'h0 && q.ttok.ctrl) begin
            d.chan0 = 1'b0;
            d.st    = ST_DRAIN;
          end else begin
            d.treq = ~q.treq;
            d.tokc = q.tokc + 2'h1;
            if (q.tokc == DEST_LAST) begin
              d.ttok = '{ctrl: 1'b1, data: END_TOK};
              d.tokc = '0;
            end else begin
              d.ttok = '{ctrl: 1'b0, data: q.dest[8*(3-q.tokc) +: 8]};
            end
          end
        end
      end
      // One read per byte; the lane is chosen by the low address bits
      ST_OTP: begin
        // Word stands only after the strobe cycle has passed
        if (q.opend) begin
          if (!q.ord) begin
            d.opend = 1'b0;
            d.fv    = 1'b1;
            d.fd    = otp_lane(otp_rdata, q.bcnt[1:0]);
            d.bcnt  = q.bcnt + 16'h0001;
          end
        end else if (q.bcnt == q.len) begin
          d.st = ST_DRAIN;
        end else if (!q.fv) begin
          d.ord   = 1'b1;
          d.oaddr = q.bcnt[OTP_AW+1:2];
          d.opend = 1'b1;
        end
      end
      // Image start waits until every byte has left the FIFO
      ST_DRAIN: begin
        if (!q.fv && !img_valid) begin
          d.done = 1'b1;
          d.st   = ST_DONE;
        end
      end
      ST_DONE: begin
        d.done = 1'b1;
      end
      default: begin
        d.st = ST_WAIT;
      end
    endcase
    if (tok_take) begin
      d.rack = q.rq_s2;
    end
  end

  // State register; the clock enable freezes it and the FIFO, not the link engine
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      q      <= '0;
      q.st   <= ST_WAIT;
      q.src  <= SRC_SPI_MST;
      q.mo   <= '{sclk: 1'b0, cs_n: 1'b1, mosi: 1'b0};
      q.moe  <= '1;
      q.sie  <= '1;
      q.ttok <= '0;
    end else if (en) begin
      q <= d;
    end
  end

  // Image buffer; a stalled consumer backs up into the SPI master and OTP paths, while the SPI slave and link drop bytes
  msbl_fifo #(
    .W (FIFO_W),
    .D (FIFO_D)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .en        (en),
    .in_valid  (q.fv),
    .in_ready  (fifo_ready),
    .in_data   (q.fd),
    .out_valid (img_valid),
    .out_ready (img_ready),
    .out_data  (img_data)
  );

  // Link engine in the link clock domain
  msbl_link u_link (
    .link_clk (link_clk),
    .rst_n    (rst_n),
    .lnk_en   (q.lnk_en),
    .rx_w     (lnk_rx_w),
    .tx_w     (lnk_tx_w),
    .tx_oe_n  (lnk_tx_oe_n),
    .pd_en    (lnk_pd_en),
    .rx_tok   (rx_tok),
    .rx_req   (rx_req),
    .rx_ack   (q.rack),
    .tx_tok   (q.ttok),
    .tx_req   (q.treq),
    .tx_ack   (tx_ack)
  );
endmodule
`default_nettype wire

// >>> rtl/msbl_fifo.sv
// Small image FIFO between the boot paths and the image consumer.
// Assumes both sides run on ref_clk; en freezes all state.
`timescale 1ns/1ns
`default_nettype none
module msbl_fifo #(
  parameter int unsigned W = 8,
  parameter int unsigned D = 4
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  input  wire logic         en,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int unsigned AW = (D > 1) ? $clog2(D) : 1;

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wr;
    logic [AW-1:0]       rd;
    logic [AW:0]         cnt;
  } msbl_fifo_st_t;

  msbl_fifo_st_t q, d;
  logic          push;
  logic          pop;

  // Honest flags from the occupancy count
  assign in_ready  = (q.cnt != (AW+1)'(D));
  assign out_valid = (q.cnt != '0);
  assign out_data  = q.mem[q.rd];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Next state; pointers wrap at the depth, not at a power of two
  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wr] = in_data;
      d.wr        = (q.wr == AW'(D - 1)) ? '0 : q.wr + 1'b1;
    end
    if (pop) begin
      d.rd = (q.rd == AW'(D - 1)) ? '0 : q.rd + 1'b1;
    end
    d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else if (en) begin
      q <= d;
    end
  end
endmodule
`default_nettype wire

// >>> rtl/msbl_link.sv
// Link-facing token engine, clocked by the link's own clock.
// Assumes tokens are handed over by toggle handshakes with held data.
`timescale 1ns/1ns
`default_nettype none
module msbl_link
  import msbl_pkg::*;
(
  // Link clock and reset
  input  wire logic            link_clk,
  input  wire logic            rst_n,
  // Level from core domain
  input  wire logic            lnk_en,
  // Link wires
  input  wire logic [1:0]      rx_w,
  output logic [1:0]           tx_w,
  output logic                 tx_oe_n,
  output logic                 pd_en,
  // Received tokens toward core
  output msbl_pkg::msbl_tok_t  rx_tok,
  output logic                 rx_req,
  input  wire logic            rx_ack,
  // Tokens to send from core
  input  wire msbl_pkg::msbl_tok_t tx_tok,
  input  wire logic            tx_req,
  output logic                 tx_ack
);
  typedef struct packed {
    logic      en_s1, en_s2;
    logic [1:0] rx_s1, rx_s2, rx_p;
    logic [8:0] rsh;
    logic [3:0] rcnt;
    msbl_tok_t tok;
    logic      rreq, ra_s1, ra_s2;
    logic      tr_s1, tr_s2, tack;
    logic [8:0] tsh;
    logic [3:0] tcnt;
    logic [1:0] tw;
  } msbl_lnk_st_t;

  msbl_lnk_st_t q, d;

  assign rx_tok  = q.tok;
  assign rx_req  = q.rreq;
  assign tx_ack  = q.tack;
  assign tx_w    = q.tw;
  assign tx_oe_n = ~q.en_s2;
  assign pd_en   = ~q.en_s2;

  // A transition on wire 0 carries a 0, on wire 1 a 1; data bits LSB first, ctrl last
  always_comb begin
    logic [1:0] chg;
    logic [8:0] nsh;
    chg = q.rx_s2 ^ q.rx_p;
    nsh = q.rsh;
    d = q;
    d.en_s1 = lnk_en;
    d.en_s2 = q.en_s1;
    d.rx_s1 = rx_w;
    d.rx_s2 = q.rx_s1;
    d.ra_s1 = rx_ack;
    d.ra_s2 = q.ra_s1;
    d.tr_s1 = tx_req;
    d.tr_s2 = q.tr_s1;
    if (!q.en_s2) begin
      d.rx_p = '0;
      d.rcnt = '0;
      d.tw   = '0;
      d.tcnt = '0;
    end else begin
      // Receive side watches the wires from their low start
      d.rx_p = q.rx_s2;
      if (chg == 2'h1 || chg == 2'h2) begin
        nsh   = {chg[1], q.rsh[8:1]};
        d.rsh = nsh;
        if (q.rcnt == TOK_LAST) begin
          d.rcnt = '0;
          // A token finishing while the last is unacknowledged is lost
          if (q.rreq == q.ra_s2) begin
            d.tok  = msbl_tok_t'(nsh);
            d.rreq = ~q.rreq;
          end
        end else begin
          d.rcnt = q.rcnt + 4'h1;
        end
      end
      // Transmit side serialises one held token per request toggle
      if (q.tcnt == '0) begin
        if (q.tr_s2 != q.tack) begin
          d.tsh  = tx_tok;
          d.tcnt = TOK_LAST + 4'h1;
        end
      end else begin
        d.tw[q.tsh[0]] = ~q.tw[q.tsh[0]];
        d.tsh  = {1'b0, q.tsh[8:1]};
        d.tcnt = q.tcnt - 4'h1;
        if (q.tcnt == 4'h1) begin
          d.tack = q.tr_s2;
        end
      end
    end
  end

  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule
`default_nettype wire
